// ### sac_pkg.sv
// Notes on behaviour
// - master role uses own advertised ability word
// - loopback bit routes transmit clock to both paths
// - one then zero on restart bit reruns negotiation
// - enable bit gates the negotiation state machine; partner word capture runs even when off
// - status bit 5 is live optical presence pin
// - status bit 4 is live lock pin
// - status bit 2 shows negotiation done
// - status bit 1 flags gigabit half duplex
// - status bit 0 shows link up
// - control bits 31 to 6 read zero
// - advertised word follows link, ack, duplex, speed layout
// - partner word valid after done, used as slave
package sac_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] OFF_CONTROL = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_ADV = 8'h18;
   localparam logic [7:0] OFF_LP_ADV = 8'h20;
   localparam logic [7:0] OFF_HOLD = 8'h04;
   // ==========================================================
   // control field positions
   localparam int CTL_ON = 0;
   localparam int CTL_RERUN = 1;
   localparam int CTL_LOOP = 4;
   localparam int CTL_MASTER = 5;
   localparam logic [5:0] CTL_MASK = 6'h33;
   localparam logic [5:0] CTL_RESET = 6'h00;
   // status field positions
   localparam int ST_LINK = 0;
   localparam int ST_FAULT = 1;
   localparam int ST_DONE = 2;
   localparam int ST_LOCK = 4;
   localparam int ST_OPTIC = 5;
   // ability word fields
   localparam int AB_LINK = 15;
   localparam int AB_ACK = 14;
   localparam int AB_DUPLEX = 12;
   localparam int AB_SPD_HI = 11;
   localparam int AB_SPD_LO = 10;
   localparam logic [1:0] SPD_GIG = 2'h2;
   localparam logic [15:0] ADV_RESET = 16'h0000;
   // ==========================================================
   // negotiation timing: settle time before done is declared
   localparam int CLK_MHZ = 10;
   localparam int SETTLE_US = 10;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   typedef enum logic [1:0] {SAC_IDLE, SAC_WAIT, SAC_DONE} sac_state_t;
endpackage : sac_pkg

// ### sac_neg_if.sv
`timescale 1ns/1ps
// ==========================================================
// negotiation control bundle between register bank and engine
interface sac_neg_if;
   logic on;
   logic rerun;
   logic master;
   logic [15:0] local_word;
   logic [15:0] partner_word;
   logic partner_valid;
   logic lock;
   logic done;
   logic fault;
   logic link;
   modport bank (output on, rerun, master, local_word, lock,
      input done, fault, link, partner_word, partner_valid);
   modport eng (input on, rerun, master, local_word, lock,
      output done, fault, link, partner_word, partner_valid);
endinterface : sac_neg_if

// ### sac_neg_engine.sv
`timescale 1ns/1ps
// ==========================================================
// negotiation engine: waits for lock and, as slave, the partner word, settles,
// then resolves speed and duplex from the chosen ability word
module sac_neg_engine (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] rx_word_i,
   input wire logic rx_word_valid_i,
   sac_neg_if.eng n
);
   sac_pkg::sac_state_t state_q, state_d;
   logic [7:0] cnt_q;
   logic [15:0] lp_q;
   logic lp_valid_q;
   wire logic [15:0] res_word;
   wire logic start_ok;

   // master resolves from its own word, slave from the partner's
   assign res_word = n.master ? n.local_word : lp_q;
   assign start_ok = n.on && n.lock && (n.master || lp_valid_q);

   // engine state; off or rerun sends it back to idle
   always_comb begin
      state_d = state_q;
      case (state_q)
         sac_pkg::SAC_IDLE: if (start_ok) state_d = sac_pkg::SAC_WAIT;
         sac_pkg::SAC_WAIT: begin
            if (!start_ok) state_d = sac_pkg::SAC_IDLE;
            else if (cnt_q == 8'(sac_pkg::SETTLE_CYC - 1))
               state_d = sac_pkg::SAC_DONE;
         end
         sac_pkg::SAC_DONE: if (!start_ok) state_d = sac_pkg::SAC_IDLE;
         default: state_d = sac_pkg::SAC_IDLE;
      endcase
      if (!n.on || n.rerun) state_d = sac_pkg::SAC_IDLE;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_q <= sac_pkg::SAC_IDLE;
         cnt_q <= 8'h00;
         lp_q <= 16'h0000;
         lp_valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d == sac_pkg::SAC_WAIT &&
            state_q == sac_pkg::SAC_WAIT) ? cnt_q + 8'h01 : 8'h00;
         if (rx_word_valid_i) begin
            lp_q <= rx_word_i;
            lp_valid_q <= 1'b1;
         end else if (n.rerun) begin
            lp_valid_q <= 1'b0;
         end
      end
   end

   // link, fault and partner_valid qualified by done so a stale word never shows a link
   assign n.done = (state_q == sac_pkg::SAC_DONE);
   assign n.link = n.done && res_word[sac_pkg::AB_LINK];
   assign n.fault = n.done && !res_word[sac_pkg::AB_DUPLEX] &&
      (res_word[sac_pkg::AB_SPD_HI:sac_pkg::AB_SPD_LO] == sac_pkg::SPD_GIG);
   assign n.partner_word = lp_q;
   assign n.partner_valid = n.done;

   a_done_needs_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      n.done |-> $past(n.on)) else $error("done while disabled");
endmodule : sac_neg_engine

// ### sac_top.sv
`timescale 1ns/1ps
// ==========================================================
// control and status register bank for one serial port
module sac_top (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   input wire logic optical_presence_pin_i,
   input wire logic lock_pin_i,
   input wire logic [15:0] rx_word_i,
   input wire logic rx_word_valid_i,
   output logic [15:0] local_ability_word_o,
   output logic negotiation_on_o,
   output logic loopback_o,
   output logic rx_clk_from_tx_o,
   output logic datapath_hold_reset_o,
   output logic link_up_o,
   output logic speed_gig_o,
   output logic full_duplex_o
);
   sac_neg_if n ();
   logic [5:0] ctl_q;
   logic [15:0] adv_q;
   logic hold_q;
   logic rerun_prev_q;
   logic rerun_pulse_q;
   logic [31:0] rdata_q;
   logic link_q, gig_q, fdx_q;
   wire logic wr_ctl, wr_adv, wr_hold;
   wire logic [31:0] status_word, rd_mux;
   wire logic [15:0] res_word;

   // ==========================================================
   // address decode; status writes hit no decode at all
   assign wr_ctl = reg_wr_i && reg_addr_i == sac_pkg::OFF_CONTROL;
   assign wr_adv = reg_wr_i && reg_addr_i == sac_pkg::OFF_ADV;
   assign wr_hold = reg_wr_i && reg_addr_i == sac_pkg::OFF_HOLD;

   // control register; reserved bits masked off on write
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctl_q <= sac_pkg::CTL_RESET;
         adv_q <= sac_pkg::ADV_RESET;
         hold_q <= 1'b0;
      end else begin
         if (wr_ctl) ctl_q <= reg_wdata_i[5:0] & sac_pkg::CTL_MASK;
         if (wr_adv) adv_q <= reg_wdata_i[15:0];
         if (wr_hold) hold_q <= reg_wdata_i[1];
      end
   end

   // restart fires on the falling edge of the bit, after a one
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rerun_prev_q <= 1'b0;
         rerun_pulse_q <= 1'b0;
      end else begin
         rerun_prev_q <= ctl_q[sac_pkg::CTL_RERUN];
         rerun_pulse_q <= rerun_prev_q &&
            !ctl_q[sac_pkg::CTL_RERUN];
      end
   end

   assign n.on = ctl_q[sac_pkg::CTL_ON];
   assign n.rerun = rerun_pulse_q;
   assign n.master = ctl_q[sac_pkg::CTL_MASTER];
   assign n.local_word = adv_q;
   assign n.lock = lock_pin_i;

   sac_neg_engine sac_neg_engine_i (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .rx_word_i(rx_word_i),
      .rx_word_valid_i(rx_word_valid_i),
      .n(n)
   );

   // ==========================================================
   // read path; pins are live, nothing latched
   assign status_word = {26'h0, optical_presence_pin_i,
      lock_pin_i, 1'b0, n.done, n.fault, n.link};
   assign rd_mux =
      (reg_addr_i == sac_pkg::OFF_CONTROL) ? {26'h0, ctl_q} :
      (reg_addr_i == sac_pkg::OFF_STATUS) ? status_word :
      (reg_addr_i == sac_pkg::OFF_ADV) ? {16'h0, adv_q} :
      (reg_addr_i == sac_pkg::OFF_LP_ADV && n.partner_valid) ?
         {16'h0, n.partner_word} :
      (reg_addr_i == sac_pkg::OFF_HOLD) ? {30'h0, hold_q, 1'b0} : 32'h0;
   assign res_word = n.master ? adv_q : n.partner_word;

   // registered outputs, one cycle behind their sources
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h0;
         link_q <= 1'b0;
         gig_q <= 1'b0;
         fdx_q <= 1'b0;
      end else begin
         rdata_q <= reg_rd_i ? rd_mux : 32'h0;
         link_q <= n.link;
         gig_q <= n.done && res_word[sac_pkg::AB_SPD_HI:sac_pkg::AB_SPD_LO]
            == sac_pkg::SPD_GIG;
         fdx_q <= n.done && res_word[sac_pkg::AB_DUPLEX];
      end
   end

   assign reg_rdata_o = rdata_q;
   assign local_ability_word_o = adv_q;
   assign negotiation_on_o = ctl_q[sac_pkg::CTL_ON];
   assign loopback_o = ctl_q[sac_pkg::CTL_LOOP];
   assign rx_clk_from_tx_o = ctl_q[sac_pkg::CTL_LOOP];
   assign datapath_hold_reset_o = hold_q;
   assign link_up_o = link_q;
   assign speed_gig_o = gig_q;
   assign full_duplex_o = fdx_q;

   // ==========================================================
   a_ctl_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $past(reg_rd_i && reg_addr_i == sac_pkg::OFF_CONTROL) |->
      reg_rdata_o[31:6] == 26'h0 && reg_rdata_o[3:2] == 2'h0)
      else $error("control reserved bits nonzero");
   a_lock_live: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $past(reg_rd_i && reg_addr_i == sac_pkg::OFF_STATUS) |->
      reg_rdata_o[4] == $past(lock_pin_i))
      else $error("lock bit not live");
   a_optic_live: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $past(reg_rd_i && reg_addr_i == sac_pkg::OFF_STATUS) |->
      reg_rdata_o[5] == $past(optical_presence_pin_i))
      else $error("presence bit not live");
   a_rerun_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      $fell(ctl_q[1]) |-> ##2 !n.done)
      else $error("restart did not drop done");
   a_off_no_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !ctl_q[0] |-> ##1 !n.done)
      else $error("negotiation while disabled");
   a_status_ro: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == sac_pkg::OFF_STATUS |=> $stable(ctl_q))
      else $error("status write changed control");
   a_fault_gig_half: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      n.fault |-> n.done && !res_word[12] && res_word[11:10] == 2'h2)
      else $error("fault without gig half");
   a_link_done: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      n.link |-> n.done && res_word[15])
      else $error("link without done");
   a_master_src: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      n.done && n.master |=>
      full_duplex_o == $past(adv_q[12]) || !$past(n.done))
      else $error("master not using own word");
endmodule : sac_top

// ### sac_phy_model.sv
`timescale 1ns/1ps
// ==========================================================
// far-side phy: sends its ability word on request, drives lock
module sac_phy_model (
   input wire logic sys_clk_i,
   input wire logic send_i,
   input wire logic lock_i,
   input wire logic [15:0] word_i,
   output logic [15:0] rx_word_o = 16'h0000,
   output logic rx_word_valid_o = 1'b0,
   output logic lock_pin_o = 1'b0
);
   logic [15:0] last_q = 16'h0000;
   // outside the pulse the word is inverted so stale data never passes
   always @(posedge sys_clk_i) begin
      rx_word_valid_o <= send_i; // phy never claims master role
      if (send_i) begin
         rx_word_o <= word_i;
         last_q <= word_i;
      end else begin
         rx_word_o <= ~last_q;
      end
      lock_pin_o <= lock_i;
   end
endmodule : sac_phy_model

// ### test_sac_top.sv
`timescale 1ns/1ps
module test_sac_top;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd_s = 1'b0;
   logic optic = 1'b1, lock_req = 1'b0, send = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [15:0] pword = 16'h0000, rx_word;
   logic rx_valid, lock_pin, loop, rxclk, hold, link, gig, full, an_on;
   logic [15:0] adv;
   int num_errors = 0, num_checks = 0;
   // ==========================================================
   // clock, design and far side
   initial begin
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   sac_top sac_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd_s),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .optical_presence_pin_i(optic), .lock_pin_i(lock_pin),
      .rx_word_i(rx_word), .rx_word_valid_i(rx_valid),
      .local_ability_word_o(adv), .negotiation_on_o(an_on),
      .loopback_o(loop), .rx_clk_from_tx_o(rxclk),
      .datapath_hold_reset_o(hold), .link_up_o(link),
      .speed_gig_o(gig), .full_duplex_o(full));
   sac_phy_model sac_phy_model_i (.sys_clk_i(sys_clk_i), .send_i(send),
      .lock_i(lock_req), .word_i(pword), .rx_word_o(rx_word),
      .rx_word_valid_o(rx_valid), .lock_pin_o(lock_pin));
   // ==========================================================
   // shared access and compare tasks
   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk_i) #1;
      addr = a; wdata = v; wr = 1'b1;
      @(posedge sys_clk_i) #1;
      wr = 1'b0;
   endtask : wreg
   // data is registered at the edge after the strobe, sampled past it
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk_i) #1;
      addr = a; rd_s = 1'b1;
      @(posedge sys_clk_i) #1;
      rd_s = 1'b0;
      v = rdata;
   endtask : rreg
   task automatic wait_done();
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 150 && !seen; i++) begin
         rreg(sac_pkg::OFF_STATUS, d);
         seen = (d[sac_pkg::ST_DONE] === 1'b1);
      end
      if (!seen) begin
         num_errors++;
         $display("Error done expected 1 seen 0");
         final_report();
      end
   endtask : wait_done
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rreg(sac_pkg::OFF_CONTROL, d); chk("ctl", d, 32'h0);
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h20);
      optic = 1'b0;
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h0);
      optic = 1'b1;
   endtask : t_reset
   task automatic t_mask();
      wreg(sac_pkg::OFF_CONTROL, 32'hffffffcc);
      rreg(sac_pkg::OFF_CONTROL, d); chk("ctl", d, 32'h0);
      wreg(sac_pkg::OFF_CONTROL, 32'hffffffff);
      rreg(sac_pkg::OFF_CONTROL, d); chk("ctl", d, 32'h33);
      wreg(sac_pkg::OFF_STATUS, 32'hffffffff);
      wreg(sac_pkg::OFF_CONTROL, 32'h0);
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h20);
      rreg(8'h08, d); chk("unmapped", d, 32'h0);
   endtask : t_mask
   task automatic t_off();
      lock_req = 1'b1;
      wreg(sac_pkg::OFF_ADV, 32'h8801);
      chk("adv", adv, 32'h8801);
      rreg(sac_pkg::OFF_ADV, d); chk("adv", d, 32'h8801);
      wreg(sac_pkg::OFF_CONTROL, 32'h20);
      repeat (130) @(posedge sys_clk_i);
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h30);
      chk("an_on", an_on, 32'h0);
   endtask : t_off
   // own word: gigabit half duplex gives the fault flag
   task automatic t_master();
      wreg(sac_pkg::OFF_CONTROL, 32'h21);
      chk("an_on", an_on, 32'h1);
      wait_done();
      chk("st", d, 32'h37);
      @(posedge sys_clk_i) #1;
      chk("gig", gig, 32'h1);
      chk("full", full, 32'h0);
      chk("link", link, 32'h1);
      // one then zero on the restart bit drops done, then it renegotiates
      wreg(sac_pkg::OFF_CONTROL, 32'h23);
      wreg(sac_pkg::OFF_CONTROL, 32'h21);
      @(posedge sys_clk_i) #1;
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h30);
      wait_done();
      chk("st", d, 32'h37);
   endtask : t_master
   // partner word decides speed and duplex; rerun clears done
   task automatic t_slave();
      wreg(sac_pkg::OFF_CONTROL, 32'h03);
      wreg(sac_pkg::OFF_CONTROL, 32'h01);
      repeat (2) @(posedge sys_clk_i);
      rreg(sac_pkg::OFF_STATUS, d); chk("st", d, 32'h30);
      rreg(sac_pkg::OFF_LP_ADV, d); chk("lp", d, 32'h0);
      @(posedge sys_clk_i) #1;
      pword = 16'hd801; send = 1'b1;
      @(posedge sys_clk_i) #1;
      send = 1'b0;
      wait_done();
      chk("st", d, 32'h35);
      rreg(sac_pkg::OFF_LP_ADV, d); chk("lp", d, 32'hd801);
      chk("full", full, 32'h1);
      chk("gig", gig, 32'h1);
   endtask : t_slave
   task automatic t_loop();
      wreg(sac_pkg::OFF_HOLD, 32'h2);
      chk("hold", hold, 32'h1);
      rreg(sac_pkg::OFF_HOLD, d); chk("hold", d, 32'h2);
      wreg(sac_pkg::OFF_CONTROL, 32'h11);
      chk("loop", loop, 32'h1);
      chk("rxclk", rxclk, 32'h1);
      wreg(sac_pkg::OFF_CONTROL, 32'h01);
      wreg(sac_pkg::OFF_HOLD, 32'h0);
      chk("loop", loop, 32'h0);
      chk("hold", hold, 32'h0);
   endtask : t_loop
   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      t_reset();
      t_mask();
      t_off();
      t_master();
      t_slave();
      t_loop();
      final_report();
   end
endmodule : test_sac_top
